// [rtl/scim_cfg.svh]
// scim_cfg.svh: addresses, layouts and reset values of the
// statistics-counter interrupt mask block.
// assumes: included by bare name from every scim source file.
`ifndef SCIM_CFG_SVH
`define SCIM_CFG_SVH

// register bus
`define SCIM_AW 12
`define SCIM_DW 32
`define SCIM_ADDR_RX_STAT 12'h104
`define SCIM_ADDR_TX_STAT 12'h108
`define SCIM_ADDR_RX_MASK 12'h10c
`define SCIM_ADDR_TX_MASK 12'h110

// counter population, one bit per counter
`define SCIM_RX_CNT 24
`define SCIM_TX_CNT 25

// writable bits; reserved bits above read as zero
`define SCIM_RX_VALID 32'h00ff_ffff
`define SCIM_TX_VALID 32'h01ff_ffff
`define SCIM_RX_RESV_LO 24
`define SCIM_TX_RESV_LO 25

// reset values
`define SCIM_MASK_RST 32'h0000_0000
`define SCIM_WORD_ZERO 32'h0000_0000

`endif

// [rtl/scim_pkg.sv]
// scim_pkg: types of the statistics-counter interrupt mask block.
// assumes: scim_cfg.svh sits on the include path.
`include "scim_cfg.svh"

package scim_pkg;

    typedef logic [`SCIM_AW-1:0] scim_addr_t;
    typedef logic [`SCIM_DW-1:0] scim_word_t;
    typedef logic [`SCIM_RX_CNT-1:0] scim_rx_vec_t;
    typedef logic [`SCIM_TX_CNT-1:0] scim_tx_vec_t;

    // decoded register select
    typedef enum logic [2:0] {
        SCIM_SEL_NONE = 3'h0,
        SCIM_SEL_RX_STAT = 3'h1,
        SCIM_SEL_TX_STAT = 3'h2,
        SCIM_SEL_RX_MASK = 3'h3,
        SCIM_SEL_TX_MASK = 3'h4
    } scim_sel_e;

    // receive counter index = bit position in status and mask
    typedef enum int {
        RXC_ALL_FRAMES = 0, RXC_ALL_OCTETS = 1, RXC_GOOD_OCTETS = 2,
        RXC_GOOD_BCAST = 3, RXC_GOOD_MCAST = 4, RXC_CRC_ERR = 5,
        RXC_ALIGN_ERR = 6, RXC_RUNT_ERR = 7, RXC_JABBER_ERR = 8,
        RXC_UNDERSIZE = 9, RXC_OVERSIZE = 10, RXC_SIZE_UPTO_64 = 11,
        RXC_SIZE_65_127 = 12, RXC_SIZE_128_255 = 13,
        RXC_SIZE_256_511 = 14, RXC_SIZE_512_1023 = 15,
        RXC_SIZE_1024_TO_MAX = 16, RXC_UNICAST = 17, RXC_LENGTH_ERR = 18,
        RXC_OUT_OF_RANGE = 19, RXC_PAUSE = 20, RXC_FIFO_OVF = 21,
        RXC_VLAN = 22, RXC_WATCHDOG = 23
    } scim_rx_cnt_e;

    // transmit counter index = bit position in status and mask
    typedef enum int {
        TXC_OCTETS_ALL = 0, TXC_FRAMES_ALL = 1, TXC_GOOD_BCAST = 2,
        TXC_GOOD_MCAST = 3, TXC_SIZE_UPTO_64 = 4, TXC_SIZE_65_127 = 5,
        TXC_SIZE_128_255 = 6, TXC_SIZE_256_511 = 7,
        TXC_SIZE_512_1023 = 8, TXC_SIZE_1024_TO_MAX = 9,
        TXC_UNICAST = 10, TXC_MULTICAST = 11, TXC_BROADCAST = 12,
        TXC_UNDERFLOW = 13, TXC_SINGLE_COL = 14, TXC_MULTI_COL = 15,
        TXC_DEFERRED = 16, TXC_LATE_COL = 17, TXC_EXCESS_COL = 18,
        TXC_CARRIER_ERR = 19, TXC_GOOD_OCTETS = 20, TXC_GOOD_FRAMES = 21,
        TXC_EXCESS_DEFER = 22, TXC_PAUSE = 23, TXC_VLAN = 24
    } scim_tx_cnt_e;

endpackage

// [rtl/scim_status_bank.sv]
// scim_status_bank: sticky half/full event bits for one group of
// counters, one slice per counter.
// assumes: level inputs come from counters on sys_clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "scim_cfg.svh"

module scim_status_bank
    import scim_pkg::*;
#(
    parameter int W = `SCIM_RX_CNT
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] msb_i,
    input wire logic [W-1:0] ones_i,
    input wire logic [W-1:0] lsb_rd_i,
    input wire logic [W-1:0] w1c_i,
    output logic [W-1:0] status_o
);

    logic [W-1:0] msb_q;
    logic [W-1:0] ones_q;
    logic [W-1:0] status_q;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_slice
            logic evt;
            // R10 half and full edges
            assign evt = (msb_i[g] & ~msb_q[g]) | (ones_i[g] & ~ones_q[g]);

            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    msb_q[g] <= 1'b0;
                    ones_q[g] <= 1'b0;
                end else begin
                    msb_q[g] <= msb_i[g];
                    ones_q[g] <= ones_i[g];
                end
            end

            // R11 lsb read clears; set wins
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    status_q[g] <= 1'b0;
                end else if (evt) begin
                    status_q[g] <= 1'b1;
                end else if (lsb_rd_i[g] | w1c_i[g]) begin
                    status_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign status_o = status_q;

endmodule
`default_nettype wire

// [rtl/scim_top.sv]
// scim_top: statistics-counter interrupt masking with its register
// slave, sticky event status and the combined interrupt line.
// assumes: counters sit on sys_clk_i and give top-bit and all-ones
// levels plus a pulse when their low byte lane is read.
//
// How it works
// R1: rx mask word, bits 31:24 reserved and read as zero.
// R2: rx mask bit one blocks both half and full events of that counter.
// R3: rx bits 23..17: watchdog, vlan, fifo ovf, pause, range, length, ucast.
// R4: rx bits 16..11: size bins 1024-max down to up-to-64.
// R5: rx bits 10..0: oversize, undersize, errors, good, octets, all frames.
// R6: tx mask word, bits 31:25 reserved and read as zero.
// R7: tx bits 24..14: vlan, pause, defer, good, carrier, collisions.
// R8: tx bits 13..0: underflow, cast types, size bins, good, frames, octets.
// R9: every mask bit read/write, zero after reset.
// R10: event when counter top bit sets and again at all ones.
// R11: status bit clears when the counter's low byte is read.
// R12: interrupt is or of status bits with mask bit zero.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "scim_cfg.svh"

module scim_top
    import scim_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [`SCIM_AW-1:0] addr_i,
    input wire logic [`SCIM_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`SCIM_DW-1:0] rdata_o,
    input wire logic [`SCIM_RX_CNT-1:0] rx_cnt_msb_i,
    input wire logic [`SCIM_RX_CNT-1:0] rx_cnt_ones_i,
    input wire logic [`SCIM_RX_CNT-1:0] rx_lsb_rd_i,
    input wire logic [`SCIM_TX_CNT-1:0] tx_cnt_msb_i,
    input wire logic [`SCIM_TX_CNT-1:0] tx_cnt_ones_i,
    input wire logic [`SCIM_TX_CNT-1:0] tx_lsb_rd_i,
    output logic irq_o
);

    scim_sel_e sel;
    scim_rx_vec_t rx_mask_q;
    scim_tx_vec_t tx_mask_q;
    scim_rx_vec_t rx_stat;
    scim_tx_vec_t tx_stat;
    scim_rx_vec_t rx_w1c;
    scim_tx_vec_t tx_w1c;
    scim_word_t rdata_q;
    scim_word_t rdata_d;
    logic irq_q;
    logic irq_d;

    // address decode; unmapped addresses select nothing
    always_comb begin
        if (addr_i == `SCIM_ADDR_RX_STAT) begin
            sel = SCIM_SEL_RX_STAT;
        end else if (addr_i == `SCIM_ADDR_TX_STAT) begin
            sel = SCIM_SEL_TX_STAT;
        end else if (addr_i == `SCIM_ADDR_RX_MASK) begin
            sel = SCIM_SEL_RX_MASK;
        end else if (addr_i == `SCIM_ADDR_TX_MASK) begin
            sel = SCIM_SEL_TX_MASK;
        end else begin
            sel = SCIM_SEL_NONE;
        end
    end

    // R9 rx mask storage
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_mask_q <= scim_rx_vec_t'(`SCIM_MASK_RST);
        end else if (wr_i && sel == SCIM_SEL_RX_MASK) begin
            rx_mask_q <= wdata_i[`SCIM_RX_CNT-1:0];
        end
    end

    // R9 tx mask storage
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_mask_q <= scim_tx_vec_t'(`SCIM_MASK_RST);
        end else if (wr_i && sel == SCIM_SEL_TX_MASK) begin
            tx_mask_q <= wdata_i[`SCIM_TX_CNT-1:0];
        end
    end

    // write one to clear, beside the low-byte read clear
    assign rx_w1c = (wr_i && sel == SCIM_SEL_RX_STAT) ?
        wdata_i[`SCIM_RX_CNT-1:0] : '0;
    assign tx_w1c = (wr_i && sel == SCIM_SEL_TX_STAT) ?
        wdata_i[`SCIM_TX_CNT-1:0] : '0;

    // port bit n belongs to counter n of scim_rx_cnt_e
    scim_status_bank #(
        .W(`SCIM_RX_CNT)
    ) u_rx_bank (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .msb_i(rx_cnt_msb_i),
        .ones_i(rx_cnt_ones_i),
        .lsb_rd_i(rx_lsb_rd_i),
        .w1c_i(rx_w1c),
        .status_o(rx_stat)
    );

    scim_status_bank #(
        .W(`SCIM_TX_CNT)
    ) u_tx_bank (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .msb_i(tx_cnt_msb_i),
        .ones_i(tx_cnt_ones_i),
        .lsb_rd_i(tx_lsb_rd_i),
        .w1c_i(tx_w1c),
        .status_o(tx_stat)
    );

    // R1 R6 reserved bits pad with zero
    always_comb begin
        rdata_d = `SCIM_WORD_ZERO;
        if (rd_i) begin
            case (sel)
                SCIM_SEL_RX_STAT: begin
                    rdata_d = scim_word_t'(rx_stat);
                end
                SCIM_SEL_TX_STAT: begin
                    rdata_d = scim_word_t'(tx_stat);
                end
                SCIM_SEL_RX_MASK: begin
                    rdata_d = scim_word_t'(rx_mask_q);
                end
                SCIM_SEL_TX_MASK: begin
                    rdata_d = scim_word_t'(tx_mask_q);
                end
                default: begin
                    rdata_d = `SCIM_WORD_ZERO;
                end
            endcase
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= `SCIM_WORD_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // R2 R3 R4 R5 R7 R8 R12 mask gates status
    // registered so the pin is glitch free, costs one cycle
    assign irq_d = |(rx_stat & ~rx_mask_q) | |(tx_stat & ~tx_mask_q);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;

    // checks

    a_rx_resv_zero: assert property ( // R1
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && sel == SCIM_SEL_RX_MASK
        |=> rdata_o[`SCIM_DW-1:`SCIM_RX_RESV_LO] == '0
    ) else $error("rx mask reserved bits not zero");

    a_tx_resv_zero: assert property ( // R6
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && sel == SCIM_SEL_TX_MASK
        |=> rdata_o[`SCIM_DW-1:`SCIM_TX_RESV_LO] == '0
    ) else $error("tx mask reserved bits not zero");

    a_all_masked_quiet: assert property ( // R2
        @(posedge sys_clk_i) disable iff (rst_i)
        (&rx_mask_q) && (&tx_mask_q) ##1 (&rx_mask_q) && (&tx_mask_q)
        |=> !irq_o
    ) else $error("interrupt with every counter masked");

    a_rx_watchdog_map: assert property ( // R3
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(rx_cnt_msb_i[RXC_WATCHDOG])
        |=> rx_stat[RXC_WATCHDOG] ##0 rx_stat[`SCIM_RX_CNT-1]
    ) else $error("watchdog event not on top rx bit");

    a_rx_bin_masked: assert property ( // R4
        @(posedge sys_clk_i) disable iff (rst_i)
        rx_mask_q[RXC_SIZE_1024_TO_MAX] &&
        (rx_stat == scim_rx_vec_t'(1) << RXC_SIZE_1024_TO_MAX) &&
        tx_stat == '0
        |=> !irq_o
    ) else $error("masked size-bin event raised interrupt");

    a_rx_frames_bit: assert property ( // R5
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(rx_cnt_ones_i[RXC_ALL_FRAMES])
        |=> rx_stat[0]
    ) else $error("all-frames event not on rx bit 0");

    a_tx_vlan_bit: assert property ( // R7
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(tx_cnt_msb_i[TXC_VLAN])
        |=> tx_stat[`SCIM_TX_CNT-1]
    ) else $error("tx vlan event not on tx bit 24");

    a_tx_octets_bit: assert property ( // R8
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(tx_cnt_ones_i[TXC_OCTETS_ALL]) && !tx_mask_q[0]
        |=> tx_stat[0] ##1 irq_o
    ) else $error("tx octet event did not reach interrupt");

    a_mask_write_back: assert property ( // R9
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_i && sel == SCIM_SEL_TX_MASK ##1 rd_i && sel == SCIM_SEL_TX_MASK
        && !wr_i
        |=> rdata_o == ($past(wdata_i, 2) & `SCIM_TX_VALID)
    ) else $error("tx mask read back differs from write");

    a_half_event_set: assert property ( // R10
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(rx_cnt_msb_i[RXC_CRC_ERR]) || $rose(rx_cnt_ones_i[RXC_CRC_ERR])
        |=> rx_stat[RXC_CRC_ERR]
    ) else $error("counter threshold did not set status");

    a_lsb_read_clear: assert property ( // R11
        @(posedge sys_clk_i) disable iff (rst_i)
        rx_stat[RXC_PAUSE] && rx_lsb_rd_i[RXC_PAUSE] &&
        !$rose(rx_cnt_msb_i[RXC_PAUSE]) && !$rose(rx_cnt_ones_i[RXC_PAUSE])
        |=> !rx_stat[RXC_PAUSE] ##1 !rx_stat[RXC_PAUSE] ||
        $past(rx_cnt_msb_i[RXC_PAUSE] | rx_cnt_ones_i[RXC_PAUSE])
    ) else $error("low byte read did not clear status");

    a_unmasked_irq: assert property ( // R12
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(rx_cnt_ones_i[RXC_UNICAST]) && !rx_mask_q[RXC_UNICAST]
        && !wr_i
        |-> ##[1:2] irq_o
    ) else $error("unmasked event missed interrupt");

    // read data are zero outside the cycle after a read strobe
    a_rdata_idle_zero: assert property ( // R9
        @(posedge sys_clk_i) disable iff (rst_i)
        !rd_i |=> rdata_o == '0
    ) else $error("read data not zero outside read cycle");

    a_unmapped_zero: assert property ( // R1
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && sel == SCIM_SEL_NONE |=> rdata_o == '0
    ) else $error("unmapped read not zero");

    a_rx_mask_write: assert property ( // R9
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_i && sel == SCIM_SEL_RX_MASK
        |=> rx_mask_q == $past(wdata_i[`SCIM_RX_CNT-1:0])
    ) else $error("rx mask write not taken");

    a_tx_mask_write: assert property ( // R9
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_i && sel == SCIM_SEL_TX_MASK
        |=> tx_mask_q == $past(wdata_i[`SCIM_TX_CNT-1:0])
    ) else $error("tx mask write not taken");

    // masks change only on their own write
    a_rx_mask_hold: assert property ( // R9
        @(posedge sys_clk_i) disable iff (rst_i)
        !(wr_i && sel == SCIM_SEL_RX_MASK) |=> $stable(rx_mask_q)
    ) else $error("rx mask changed without write");

    a_tx_mask_hold: assert property ( // R9
        @(posedge sys_clk_i) disable iff (rst_i)
        !(wr_i && sel == SCIM_SEL_TX_MASK) |=> $stable(tx_mask_q)
    ) else $error("tx mask changed without write");

    a_rx_src_irq: assert property ( // R12
        @(posedge sys_clk_i) disable iff (rst_i)
        (rx_stat & ~rx_mask_q) != '0 |=> irq_o
    ) else $error("unmasked rx status without interrupt");

    a_tx_src_irq: assert property ( // R12
        @(posedge sys_clk_i) disable iff (rst_i)
        (tx_stat & ~tx_mask_q) != '0 |=> irq_o
    ) else $error("unmasked tx status without interrupt");

    a_masked_no_irq: assert property ( // R2
        @(posedge sys_clk_i) disable iff (rst_i)
        (rx_stat & ~rx_mask_q) == '0 && (tx_stat & ~tx_mask_q) == '0
        |=> !irq_o
    ) else $error("interrupt with no unmasked status");

    // status reads show the bits as they stood at the strobe
    a_rx_stat_read: assert property ( // R10
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && sel == SCIM_SEL_RX_STAT
        |=> rdata_o == scim_word_t'($past(rx_stat))
    ) else $error("rx status read differs");

    a_tx_stat_read: assert property ( // R10
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && sel == SCIM_SEL_TX_STAT
        |=> rdata_o == scim_word_t'($past(tx_stat))
    ) else $error("tx status read differs");

    c_tx_full_irq: cover property (
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(tx_cnt_ones_i[TXC_OCTETS_ALL]) ##2 irq_o
    );

    c_rx_event_irq: cover property (
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(rx_cnt_msb_i[RXC_WATCHDOG]) ##[1:2] $rose(irq_o)
    );

    c_masked_event: cover property (
        @(posedge sys_clk_i) disable iff (rst_i)
        rx_mask_q[RXC_VLAN] && $rose(rx_stat[RXC_VLAN]) && !irq_o
    );

    c_lsb_clear: cover property (
        @(posedge sys_clk_i) disable iff (rst_i)
        tx_stat[TXC_PAUSE] ##1 !tx_stat[TXC_PAUSE]
    );

    c_irq_drop: cover property (
        @(posedge sys_clk_i) disable iff (rst_i)
        irq_o ##1 !irq_o
    );

endmodule
`default_nettype wire

// [verif/scim_top_tb.sv]
// scim_top_tb: self-checking bench for the counter interrupt masks.
// assumes: scim_top from rtl, one 50 MHz clock, bench drives counters.
`timescale 1ns/1ns
`default_nettype none
`include "scim_cfg.svh"

module scim_top_tb
    import scim_pkg::*;
;
    logic sys_clk_i;
    logic rst_i;
    logic wr_i;
    logic rd_i;
    logic irq_o;
    scim_addr_t addr_i;
    scim_word_t wdata_i;
    scim_word_t rdata_o;
    // [tx][kind]: kind 0 top bit, 1 all ones, 2 low byte read
    scim_word_t ev [2][3];
    int n_fail;
    int n_compared;
    int cyc = 0;

    scim_top scim_top_inst (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .rx_cnt_msb_i(ev[0][0][`SCIM_RX_CNT-1:0]),
        .rx_cnt_ones_i(ev[0][1][`SCIM_RX_CNT-1:0]),
        .rx_lsb_rd_i(ev[0][2][`SCIM_RX_CNT-1:0]),
        .tx_cnt_msb_i(ev[1][0][`SCIM_TX_CNT-1:0]),
        .tx_cnt_ones_i(ev[1][1][`SCIM_TX_CNT-1:0]),
        .tx_lsb_rd_i(ev[1][2][`SCIM_TX_CNT-1:0]),
        .irq_o(irq_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ceiling well above the ~1700 cycles the tests need
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            final_report();
        end
    end

    task automatic check(input scim_word_t seen, input scim_word_t exp,
                         input string msg);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input scim_addr_t a, input scim_word_t d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe: sample mid-cycle
    task automatic rd(input scim_addr_t a, output scim_word_t d);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(negedge sys_clk_i);
        d = rdata_o;
    endtask

    task automatic set_ev(input bit tx, input int kind, input scim_word_t v);
        @(posedge sys_clk_i);
        ev[tx][kind] <= v;
    endtask

    // status one edge after the event, irq one more
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask

    task automatic t_regs();
        scim_word_t d;
        rd(`SCIM_ADDR_RX_MASK, d);
        check(d, `SCIM_MASK_RST, "rx mask reset");
        rd(`SCIM_ADDR_TX_MASK, d);
        check(d, `SCIM_MASK_RST, "tx mask reset");
        check(32'(irq_o), 32'h0000_0000, "irq after reset");
        wr(`SCIM_ADDR_RX_MASK, 32'hffff_ffff);
        wr(`SCIM_ADDR_TX_MASK, 32'hffff_ffff);
        wr(12'h114, 32'hffff_ffff);
        rd(`SCIM_ADDR_RX_MASK, d);
        check(d, 32'h00ff_ffff, "rx reserved bits");
        rd(`SCIM_ADDR_TX_MASK, d);
        check(d, 32'h01ff_ffff, "tx reserved bits");
        rd(12'h114, d);
        check(d, `SCIM_WORD_ZERO, "unmapped read");
        wr(`SCIM_ADDR_RX_MASK, 32'h5a5a_5a5a);
        rd(`SCIM_ADDR_RX_MASK, d);
        check(d, 32'h005a_5a5a, "rx mask pattern");
        // second reset in mid-run must clear masks again
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(`SCIM_ADDR_RX_MASK, d);
        check(d, `SCIM_MASK_RST, "rx mask after reset");
        rd(`SCIM_ADDR_TX_MASK, d);
        check(d, `SCIM_MASK_RST, "tx mask after reset");
        $display("test regs done");
    endtask

    // mask only bit i, fire its counter, then unmask only bit i
    task automatic t_bit(input bit tx, input int i);
        scim_word_t d;
        scim_word_t b;
        scim_addr_t ma;
        scim_addr_t sa;
        b = 32'h0000_0001 << i;
        ma = tx ? `SCIM_ADDR_TX_MASK : `SCIM_ADDR_RX_MASK;
        sa = tx ? `SCIM_ADDR_TX_STAT : `SCIM_ADDR_RX_STAT;
        wr(ma, b);
        set_ev(tx, i % 2, b);
        set_ev(tx, i % 2, 32'h0000_0000);
        settle(3);
        check(32'(irq_o), 32'h0000_0000, "masked event irq");
        rd(sa, d);
        check(d, b, "status after event");
        wr(ma, (tx ? `SCIM_TX_VALID : `SCIM_RX_VALID) & ~b);
        settle(3);
        check(32'(irq_o), 32'h0000_0001, "unmasked irq");
        if (i == 0) begin
            wr(sa, b);
        end else begin
            set_ev(tx, 2, b);
            set_ev(tx, 2, 32'h0000_0000);
        end
        settle(3);
        check(32'(irq_o), 32'h0000_0000, "irq after clear");
        rd(sa, d);
        check(d, `SCIM_WORD_ZERO, "status after clear");
        // other threshold kind, unmasked, cleared the other way
        set_ev(tx, 1 - (i % 2), b);
        set_ev(tx, 1 - (i % 2), 32'h0000_0000);
        settle(3);
        check(32'(irq_o), 32'h0000_0001, "second event irq");
        if (i == 0) begin
            set_ev(tx, 2, b);
            set_ev(tx, 2, 32'h0000_0000);
        end else begin
            wr(sa, b);
        end
        settle(3);
        check(32'(irq_o), 32'h0000_0000, "irq after second clear");
        rd(sa, d);
        check(d, `SCIM_WORD_ZERO, "status after second clear");
    endtask

    // write then read with no gap; read data stand one cycle only
    task automatic t_b2b();
        scim_word_t d;
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= `SCIM_ADDR_TX_MASK;
        wdata_i <= 32'hfedc_ba98;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(negedge sys_clk_i);
        d = rdata_o;
        check(d, 32'h00dc_ba98, "tx mask back to back");
        @(negedge sys_clk_i);
        check(rdata_o, `SCIM_WORD_ZERO, "read data after its cycle");
        $display("test back to back done");
    endtask

    // half-maximum then all-ones on one counter: two separate events
    task automatic t_twice();
        scim_word_t d;
        wr(`SCIM_ADDR_TX_MASK, 32'h0000_0000);
        set_ev(1'b1, 0, 32'h0100_0000);
        settle(3);
        check(32'(irq_o), 32'h0000_0001, "half-max irq");
        set_ev(1'b1, 2, 32'h0100_0000);
        set_ev(1'b1, 2, 32'h0000_0000);
        settle(3);
        check(32'(irq_o), 32'h0000_0000, "cleared before full");
        set_ev(1'b1, 1, 32'h0100_0000);
        settle(3);
        rd(`SCIM_ADDR_TX_STAT, d);
        check(d, 32'h0100_0000, "full-max status");
        check(32'(irq_o), 32'h0000_0001, "full-max irq");
        set_ev(1'b1, 0, 32'h0000_0000);
        set_ev(1'b1, 1, 32'h0000_0000);
        wr(`SCIM_ADDR_TX_STAT, 32'h0100_0000);
        settle(3);
        check(32'(irq_o), 32'h0000_0000, "irq dropped");
        $display("test twice done");
    endtask

    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        ev = '{default: '0};
        n_fail = 0;
        n_compared = 0;
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_b2b();
        for (int i = 0; i < `SCIM_RX_CNT; i++) begin
            t_bit(1'b0, i);
        end
        $display("test rx bits done");
        for (int i = 0; i < `SCIM_TX_CNT; i++) begin
            t_bit(1'b1, i);
        end
        $display("test tx bits done");
        t_twice();
        final_report();
    end
endmodule
`default_nettype wire
